// *** logic/srs_status.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "srs_regs.svh"
module srs_status
  import srs_pkg::*;
#(
  parameter bit HAS_SOURCE = 1'b1
)
(
  input wire logic REF_CLK_IN,
  input wire logic RESET_IN,
  input wire logic CLK_EN_IN,
  input wire logic MASK_WRITE_IN,
  input wire logic [7:0] MASK_VALUE_IN,
  input wire logic SAVE_DEFAULTS_COMMAND_IN,
  input wire logic DEVICE_CLEAR_IN,
  input wire logic READING_DONE_IN,
  input wire logic READING_OVERRANGE_IN,
  input wire logic STORE_FULL_IN,
  input wire logic STORE_HALF_IN,
  input wire logic STORE_REARM_IN,
  input wire logic READING_SENT_IN,
  input wire logic READY_IN,
  input wire logic ERROR_EVENT_IN,
  input wire logic ERROR_STATUS_WORD_READ_IN,
  input wire logic SOURCE_FAULT_IN,
  input wire logic SOURCE_ERROR_STATUS_WORD_READ_IN,
  input wire logic SERIAL_POLL_IN,
  output logic SRQ_OUT,
  output logic [7:0] POLL_STATUS_BYTE_OUT,
  output logic [7:0] SERVICE_REQUEST_MASK_OUT
);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [1:0] sync_a_reg;
  logic [1:0] sync_b_reg;
  logic [1:0] src_sync;
  assign src_sync = {SOURCE_FAULT_IN, READY_IN};

  always_ff @(posedge REF_CLK_IN or posedge RESET_IN)
  begin
    if (RESET_IN)
    begin
      sync_a_reg <= 2'h0;
      sync_b_reg <= 2'h0;
    end
    else if (CLK_EN_IN)
    begin
      sync_a_reg <= src_sync;
      sync_b_reg <= sync_a_reg;
    end
  end

  logic ready_s;
  logic source_fault_s;
  assign ready_s = sync_b_reg[0];
  assign source_fault_s = sync_b_reg[1] & HAS_SOURCE;

  // ----------------------------------------
  // mask and saved default
  // ----------------------------------------
  srs_byte_t mask_reg;
  srs_byte_t saved_mask_reg;

  // saved default survives device clear; only power-up reset restores factory value
  always_ff @(posedge REF_CLK_IN or posedge RESET_IN)
  begin
    if (RESET_IN)
      saved_mask_reg <= `SRS_MASK_RESET;
    else if (CLK_EN_IN && SAVE_DEFAULTS_COMMAND_IN)
      saved_mask_reg <= mask_reg;
  end

  always_ff @(posedge REF_CLK_IN or posedge RESET_IN)
  begin
    if (RESET_IN)
      mask_reg <= `SRS_MASK_RESET;
    else if (CLK_EN_IN)
    begin
      if (DEVICE_CLEAR_IN)
        mask_reg <= saved_mask_reg;
      else if (MASK_WRITE_IN)
        mask_reg <= MASK_VALUE_IN;
    end
  end

  // ----------------------------------------
  // condition bits
  // ----------------------------------------
  srs_byte_t cond_reg;
  srs_byte_t cond_live;

  always_ff @(posedge REF_CLK_IN or posedge RESET_IN)
  begin
    if (RESET_IN)
      cond_reg <= 8'h00;
    else if (CLK_EN_IN)
    begin
      if (READING_DONE_IN)
        cond_reg[`SRS_BIT_OVERFLOW] <= READING_OVERRANGE_IN;
      // sets win over clears when they collide
      if (STORE_FULL_IN)
        cond_reg[`SRS_BIT_STORE_FULL] <= 1'b1;
      else if (STORE_REARM_IN)
        cond_reg[`SRS_BIT_STORE_FULL] <= 1'b0;
      if (STORE_HALF_IN)
        cond_reg[`SRS_BIT_STORE_HALF] <= 1'b1;
      else if (STORE_REARM_IN)
        cond_reg[`SRS_BIT_STORE_HALF] <= 1'b0;
      if (READING_DONE_IN)
        cond_reg[`SRS_BIT_READING_DONE] <= 1'b1;
      else if (READING_SENT_IN)
        cond_reg[`SRS_BIT_READING_DONE] <= 1'b0;
      if (ERROR_EVENT_IN)
        cond_reg[`SRS_BIT_ERROR] <= 1'b1;
      else if (ERROR_STATUS_WORD_READ_IN)
        cond_reg[`SRS_BIT_ERROR] <= 1'b0;
      // clears only once the fault is gone
      if (source_fault_s)
        cond_reg[`SRS_BIT_SOURCE_ERROR] <= 1'b1;
      else if (SOURCE_ERROR_STATUS_WORD_READ_IN)
        cond_reg[`SRS_BIT_SOURCE_ERROR] <= 1'b0;
    end
  end

  always_comb
  begin
    cond_live = cond_reg;
    cond_live[`SRS_BIT_READY] = ready_s;
    cond_live[`SRS_BIT_RQS] = 1'b0;
  end

  // ----------------------------------------
  // request state and latched byte
  // ----------------------------------------
  srs_state_t state_reg;
  srs_byte_t latched_reg;
  logic masked_hit;
  logic [7:0] hit_vec;

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_hit
      assign hit_vec[gi] = cond_live[gi] & mask_reg[gi];
    end
  endgenerate

  assign masked_hit = |hit_vec;

  always_ff @(posedge REF_CLK_IN or posedge RESET_IN)
  begin
    if (RESET_IN)
    begin
      state_reg <= SRS_IDLE;
      latched_reg <= 8'h00;
    end
    else if (CLK_EN_IN)
    begin
      case (state_reg)
        SRS_IDLE:
        begin
          if (masked_hit)
          begin
            state_reg <= SRS_REQUEST;
            latched_reg <= cond_live | 8'h40;
          end
        end
        SRS_REQUEST:
        begin
          if (SERIAL_POLL_IN)
            state_reg <= SRS_POLLED;
        end
        SRS_POLLED:
        begin
          // rearm only after the cause drops, so one event gives one request
          if (!masked_hit)
            state_reg <= SRS_IDLE;
        end
        default:
          state_reg <= SRS_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  always_ff @(posedge REF_CLK_IN or posedge RESET_IN)
  begin
    if (RESET_IN)
      POLL_STATUS_BYTE_OUT <= 8'h00;
    else if (CLK_EN_IN)
    begin
      if (state_reg == SRS_REQUEST)
        POLL_STATUS_BYTE_OUT <= latched_reg;
      else
        POLL_STATUS_BYTE_OUT <= cond_live;
    end
  end

  assign SRQ_OUT = (state_reg == SRS_REQUEST);
  assign SERVICE_REQUEST_MASK_OUT = mask_reg;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_request_up;
    state_reg == SRS_IDLE && masked_hit && CLK_EN_IN;
  endsequence

  property p_srq_raise;
    @(posedge REF_CLK_IN) disable iff (RESET_IN)
    s_request_up |=> SRQ_OUT;
  endproperty
  a_srq_raise: assert property (p_srq_raise) else $error("srq not raised");

  property p_poll_release;
    @(posedge REF_CLK_IN) disable iff (RESET_IN)
    SRQ_OUT && SERIAL_POLL_IN && CLK_EN_IN |=> !SRQ_OUT;
  endproperty
  a_poll_release: assert property (p_poll_release) else $error("srq held after poll");

  property p_rqs_bit;
    @(posedge REF_CLK_IN) disable iff (RESET_IN)
    SRQ_OUT && CLK_EN_IN |=> POLL_STATUS_BYTE_OUT[6];
  endproperty
  a_rqs_bit: assert property (p_rqs_bit) else $error("rqs missing");

  property p_mask_zero;
    @(posedge REF_CLK_IN) disable iff (RESET_IN)
    MASK_WRITE_IN && !DEVICE_CLEAR_IN && CLK_EN_IN && MASK_VALUE_IN == 8'h00 |=> !masked_hit;
  endproperty
  a_mask_zero: assert property (p_mask_zero) else $error("zero mask enables");

  property p_mask_write;
    @(posedge REF_CLK_IN) disable iff (RESET_IN)
    MASK_WRITE_IN && !DEVICE_CLEAR_IN && CLK_EN_IN |=> mask_reg == $past(MASK_VALUE_IN);
  endproperty
  a_mask_write: assert property (p_mask_write) else $error("mask not replaced");

  property p_clear_reload;
    @(posedge REF_CLK_IN) disable iff (RESET_IN)
    DEVICE_CLEAR_IN && CLK_EN_IN |=> mask_reg == $past(saved_mask_reg);
  endproperty
  a_clear_reload: assert property (p_clear_reload) else $error("clear missed default");

  property p_full_set;
    @(posedge REF_CLK_IN) disable iff (RESET_IN)
    STORE_FULL_IN && CLK_EN_IN |=> cond_reg[`SRS_BIT_STORE_FULL];
  endproperty
  a_full_set: assert property (p_full_set) else $error("full bit not set");

  property p_ready_live;
    @(posedge REF_CLK_IN) disable iff (RESET_IN)
    state_reg != SRS_REQUEST && CLK_EN_IN |=> POLL_STATUS_BYTE_OUT[4] == $past(ready_s);
  endproperty
  a_ready_live: assert property (p_ready_live) else $error("ready not live");

  property p_save;
    @(posedge REF_CLK_IN) disable iff (RESET_IN)
    SAVE_DEFAULTS_COMMAND_IN && CLK_EN_IN |=> saved_mask_reg == $past(mask_reg);
  endproperty
  a_save: assert property (p_save) else $error("save missed");

  property p_rqs_clear;
    @(posedge REF_CLK_IN) disable iff (RESET_IN)
    state_reg != SRS_REQUEST && CLK_EN_IN |=> !POLL_STATUS_BYTE_OUT[`SRS_BIT_RQS];
  endproperty
  a_rqs_clear: assert property (p_rqs_clear) else $error("rqs left after poll");

  property p_error_set;
    @(posedge REF_CLK_IN) disable iff (RESET_IN)
    ERROR_EVENT_IN && CLK_EN_IN |=> cond_reg[`SRS_BIT_ERROR];
  endproperty
  a_error_set: assert property (p_error_set) else $error("error bit not set");

  // enable low must hold the mask, condition bits, poll byte and the request machine
  property p_freeze;
    @(posedge REF_CLK_IN) disable iff (RESET_IN)
    !CLK_EN_IN |=> $stable(mask_reg) && $stable(cond_reg) && $stable(state_reg) && $stable(POLL_STATUS_BYTE_OUT);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while disabled");

endmodule
`default_nettype wire

// *** logic/srs_regs.svh ***
`ifndef SRS_REGS_SVH
`define SRS_REGS_SVH
// status byte bit positions, shared by mask and poll byte
`define SRS_BIT_OVERFLOW 3'd0
`define SRS_BIT_STORE_FULL 3'd1
`define SRS_BIT_STORE_HALF 3'd2
`define SRS_BIT_READING_DONE 3'd3
`define SRS_BIT_READY 3'd4
`define SRS_BIT_ERROR 3'd5
`define SRS_BIT_RQS 3'd6
`define SRS_BIT_SOURCE_ERROR 3'd7
// factory mask: requests disabled
`define SRS_MASK_RESET 8'h00
`define SRS_MASK_ALL_OFF 8'h00
`endif

// *** logic/srs_pkg.sv ***
package srs_pkg;
  typedef logic [7:0] srs_byte_t;
  typedef enum logic [1:0] {SRS_IDLE, SRS_REQUEST, SRS_POLLED} srs_state_t;
endpackage

// *** testbench/srs_poller.sv ***
`timescale 1ns/100ps
`default_nettype none
module srs_poller
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic srq_in,
  output logic poll_out
);
  // ----------------------------------------
  // slow controller: polls once per request
  // ----------------------------------------
  logic [2:0] wait_reg;
  logic busy_reg;
  // the delay leaves time to see the latched byte before the poll
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      wait_reg <= 3'h0;
      busy_reg <= 1'b0;
      poll_out <= 1'b0;
    end
    else
    begin
      poll_out <= 1'b0;
      if (!srq_in)
      begin
        busy_reg <= 1'b0;
        wait_reg <= 3'h0;
      end
      else if (!busy_reg)
      begin
        wait_reg <= wait_reg + 3'h1;
        if (wait_reg == 3'h7)
        begin
          poll_out <= 1'b1;
          busy_reg <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// *** testbench/srs_status_test.sv ***
`timescale 1ns/100ps
`default_nettype none
module srs_status_test;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [10:0] pv = 11'h000;
  logic [7:0] mval = 8'h00;
  logic ovr = 1'b0;
  logic rdy = 1'b0;
  logic sf = 1'b0;
  logic en = 1'b1;
  logic poll;
  logic srq;
  logic [7:0] stat;
  logic [7:0] mask;
  int err_total = 0;
  int n_checks = 0;
  int cyc = 0;
  // ----------------------------------------
  // clock, reset, hang guard
  // ----------------------------------------
  initial forever #2.5 clk = ~clk;
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      err_total++;
      give_verdict();
    end
  end
  srs_poller poller (.clk_in(clk), .rst_in(rst), .srq_in(srq), .poll_out(poll));
  srs_status dut (.REF_CLK_IN(clk), .RESET_IN(rst), .CLK_EN_IN(en), .MASK_WRITE_IN(pv[0]),
    .MASK_VALUE_IN(mval), .SAVE_DEFAULTS_COMMAND_IN(pv[1]), .DEVICE_CLEAR_IN(pv[2]),
    .READING_DONE_IN(pv[3]), .READING_OVERRANGE_IN(ovr), .STORE_FULL_IN(pv[4]), .STORE_HALF_IN(pv[5]),
    .STORE_REARM_IN(pv[6]), .READING_SENT_IN(pv[7]), .READY_IN(rdy), .ERROR_EVENT_IN(pv[8]),
    .ERROR_STATUS_WORD_READ_IN(pv[9]), .SOURCE_FAULT_IN(sf), .SOURCE_ERROR_STATUS_WORD_READ_IN(pv[10]),
    .SERIAL_POLL_IN(poll), .SRQ_OUT(srq), .POLL_STATUS_BYTE_OUT(stat), .SERVICE_REQUEST_MASK_OUT(mask));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk8(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic chk1(input string nm, input logic exp, input logic got);
    n_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED %s expected %b seen %b", nm, exp, got);
    end
  endtask
  // settles on falling edges so reads never race the launch edge
  task automatic pulse(input int i);
    @(posedge clk);
    pv[i] <= 1'b1;
    @(posedge clk);
    pv[i] <= 1'b0;
    repeat (5) @(negedge clk);
  endtask
  task automatic wr_mask(input logic [7:0] v);
    @(posedge clk);
    mval <= v;
    pulse(0);
    chk8("mask", v, mask);
  endtask
  task automatic wait_srq(input logic v);
    int n;
    n = 0;
    while (srq !== v && n < 40)
    begin
      @(negedge clk);
      n++;
    end
    chk1("srq", v, srq);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_mask();
    wr_mask(8'h03);
    wr_mask(8'h20);
    $display("mask write done");
  endtask
  task automatic t_srq();
    pulse(8);
    wait_srq(1'b1);
    repeat (2) @(negedge clk);
    chk8("latched byte", 8'h60, stat);
    wait_srq(1'b0);
    repeat (3) @(negedge clk);
    chk8("byte after poll", 8'h20, stat);
    pulse(9);
    chk8("error cleared", 8'h00, stat);
    $display("request and poll done");
  endtask
  task automatic t_save();
    wr_mask(8'h05);
    pulse(1);
    wr_mask(8'h10);
    pulse(2);
    chk8("restored mask", 8'h05, mask);
    wr_mask(8'h00);
    $display("save and clear done");
  endtask
  task automatic t_live();
    @(posedge clk);
    ovr <= 1'b1;
    pulse(3);
    chk8("done overrange", 8'h09, stat);
    chk1("no request", 1'b0, srq);
    pulse(7);
    chk8("sent", 8'h01, stat);
    @(posedge clk);
    ovr <= 1'b0;
    pulse(3);
    chk8("on scale", 8'h08, stat);
    pulse(7);
    pulse(5);
    chk8("half", 8'h04, stat);
    pulse(4);
    chk8("full", 8'h06, stat);
    pulse(6);
    chk8("rearm", 8'h00, stat);
    $display("live conditions done");
  endtask
  task automatic t_pins();
    @(posedge clk);
    rdy <= 1'b1;
    sf <= 1'b1;
    repeat (8) @(negedge clk);
    chk8("ready fault", 8'h90, stat);
    @(posedge clk);
    rdy <= 1'b0;
    sf <= 1'b0;
    repeat (8) @(negedge clk);
    chk8("fault held", 8'h80, stat);
    pulse(10);
    chk8("fault read", 8'h00, stat);
    $display("pin conditions done");
  endtask
  task automatic t_multi();
    wr_mask(8'h43);
    chk1("bit6 mask only", 1'b0, srq);
    pulse(4);
    wait_srq(1'b1);
    chk8("latched full", 8'h42, stat);
    wait_srq(1'b0);
    repeat (3) @(negedge clk);
    chk8("full after poll", 8'h02, stat);
    @(posedge clk);
    en <= 1'b0;
    pulse(6);
    chk8("frozen rearm", 8'h02, stat);
    @(posedge clk);
    en <= 1'b1;
    pulse(6);
    chk8("rearm after poll", 8'h00, stat);
    chk1("no repeat request", 1'b0, srq);
    wr_mask(8'h00);
    $display("multi condition done");
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk8("reset mask", 8'h00, mask);
    t_mask();
    t_srq();
    t_save();
    t_live();
    t_pins();
    t_multi();
    give_verdict();
  end
endmodule
`default_nettype wire
